/* File: core/jog_motion_control.sv */
`timescale 1ns/1ps

// Behaviour
// - Writing the jog code to the mode selector selects and starts jog at once.
// - A new direction request first moves the axis by the inching distance.
// - Request still held after the wait time switches to continuous running.
// - Zero inching distance goes straight to continuous running, ignoring wait.
// - Request bit 0 clockwise, bit 1 counterclockwise, bit 2 fast; values 0 to 7.
// - Slow speed in rpm, 1 to 13200, default 60, kept.
// - Fast speed in rpm, 1 to 13200, default 180, kept.
// - Wait time in ms, 1 to 32767, default 500, only with nonzero distance.
// - Inching distance is a 32-bit step, negative values rejected, default 20.
// - Jog completes when the motor stopped and the request is released.
// - Jog also completes when the motor stopped after halt or error.
// - Start point is the axis position when the direction request is taken, user units.
// - New jog parameters take effect immediately when received.
// - Keypad menu energizes motor, arrows run it, enter with arrow toggles speed.
module jog_motion_control #(
	parameter int MS_CYCLES = jog_pkg::MS_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        param_write,
	input  wire logic        param_read,
	input  wire logic [15:0] param_address,
	input  wire logic [31:0] param_write_data,
	output logic      [31:0] param_read_data,
	output logic             param_read_valid,
	output logic             param_error,
	input  wire logic [15:0] max_ramp_speed,
	input  wire logic [31:0] axis_position,
	input  wire logic        motor_stopped,
	input  wire logic        halt,
	input  wire logic        fault,
	input  wire logic        keypad_jog_menu,
	input  wire logic        keypad_up_key,
	input  wire logic        keypad_down_key,
	input  wire logic        keypad_enter_key,
	output logic             power_enable,
	output logic             jog_active,
	output logic             inch_request,
	output logic      [31:0] inch_target,
	output logic             run_continuous,
	output logic             run_ccw,
	output logic      [15:0] speed_ref,
	output logic             jog_done
);
	import jog_pkg::*;

	localparam int PW = $clog2(MS_CYCLES + 1);
	localparam logic [PW-1:0] PRESCALE_LAST = PW'(MS_CYCLES - 1);
	jog_state_type state, next_state;
	logic [15:0]   opmode_select, jog_request, jog_slow_speed, jog_fast_speed, jog_wait_time;
	logic [15:0]   ms_count, clamped_speed;
	logic [31:0]   jog_inch_distance, next_target, status_word;
	logic [PW-1:0] prescale;
	logic          fieldbus_jog, keypad_fast, enter_prev;
	logic          addr_ok, value_ok, write_ok, mode_request, dir_valid, dir_ccw;
	logic          use_fast, wait_elapsed, abort, next_inch_request, next_done;
	logic [1:0]    dir_bits;

	// Address decode and range check of a parameter write.
	always_comb begin
		addr_ok  = 1'b1;
		value_ok = 1'b1;
		unique case (param_address)
			ADDR_OPMODE: begin
				value_ok = ($signed(param_write_data[15:0]) >= $signed(OPMODE_MIN)) &&
					($signed(param_write_data[15:0]) <= $signed(OPMODE_MAX));
			end
			ADDR_JOG_REQUEST: value_ok = (param_write_data[15:0] <= REQ_MAX);
			ADDR_SLOW_SPEED, ADDR_FAST_SPEED: begin
				value_ok = (param_write_data[15:0] >= SPEED_MIN) &&
					(param_write_data[15:0] <= SPEED_MAX);
			end
			ADDR_INCH_DISTANCE: value_ok = !param_write_data[31];
			ADDR_WAIT_TIME: begin
				value_ok = (param_write_data[15:0] >= WAIT_MIN) &&
					(param_write_data[15:0] <= WAIT_MAX);
			end
			ADDR_JOG_STATUS:    value_ok = 1'b0;
			default: begin
				addr_ok  = 1'b0;
				value_ok = 1'b0;
			end
		endcase
		write_ok = param_write && addr_ok && value_ok;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			opmode_select     <= RESET_OPMODE;
			jog_request       <= RESET_JOG_REQUEST;
			jog_slow_speed    <= RESET_SLOW_SPEED;
			jog_fast_speed    <= RESET_FAST_SPEED;
			jog_inch_distance <= RESET_INCH_DISTANCE;
			jog_wait_time     <= RESET_WAIT_TIME;
		end else if (ce && write_ok) begin
			unique case (param_address)
				ADDR_OPMODE:        opmode_select     <= param_write_data[15:0];
				ADDR_JOG_REQUEST:   jog_request       <= param_write_data[15:0];
				ADDR_SLOW_SPEED:    jog_slow_speed    <= param_write_data[15:0];
				ADDR_FAST_SPEED:    jog_fast_speed    <= param_write_data[15:0];
				ADDR_INCH_DISTANCE: jog_inch_distance <= param_write_data;
				ADDR_WAIT_TIME:     jog_wait_time     <= param_write_data[15:0];
				default: begin
				end
			endcase
		end
	end

	assign status_word = {16'h0000, 4'h0, keypad_fast, run_ccw, run_continuous,
		jog_active, 2'b00, state};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			param_read_data  <= 32'h0000_0000;
			param_read_valid <= 1'b0;
			param_error      <= 1'b0;
		end else if (ce) begin
			param_read_valid <= param_read && addr_ok;
			param_error      <= (param_write && !write_ok) || (param_read && !addr_ok);
			if (param_read) begin
				unique case (param_address)
					ADDR_OPMODE:        param_read_data <= {{16{opmode_select[15]}}, opmode_select};
					ADDR_JOG_REQUEST:   param_read_data <= {16'h0000, jog_request};
					ADDR_SLOW_SPEED:    param_read_data <= {16'h0000, jog_slow_speed};
					ADDR_FAST_SPEED:    param_read_data <= {16'h0000, jog_fast_speed};
					ADDR_INCH_DISTANCE: param_read_data <= jog_inch_distance;
					ADDR_WAIT_TIME:     param_read_data <= {16'h0000, jog_wait_time};
					ADDR_JOG_STATUS:    param_read_data <= status_word;
					default:            param_read_data <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Mode write selects and starts jog.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fieldbus_jog <= 1'b0;
		end else if (ce) begin
			if (write_ok && param_address == ADDR_OPMODE) begin
				fieldbus_jog <= (param_write_data[15:0] == OPMODE_JOG);
			end else if (state == st_ending) begin
				fieldbus_jog <= 1'b0;
			end
		end
	end

	// Enter pressed with an arrow toggles slow and fast.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			keypad_fast <= 1'b0;
			enter_prev  <= 1'b0;
		end else if (ce) begin
			enter_prev  <= keypad_enter_key;
			keypad_fast <= keypad_fast ^ (keypad_jog_menu && keypad_enter_key &&
				!enter_prev && (keypad_up_key || keypad_down_key));
		end
	end

	always_comb begin
		mode_request = keypad_jog_menu || fieldbus_jog;
		dir_bits = keypad_jog_menu ? {keypad_down_key, keypad_up_key}
			: {jog_request[REQ_CCW_BIT], jog_request[REQ_CW_BIT]};
		use_fast = keypad_jog_menu ? keypad_fast : jog_request[REQ_FAST_BIT];
		// Both bits set is no motion.
		dir_valid = dir_bits[0] ^ dir_bits[1];
		dir_ccw   = dir_bits[1];
		abort     = halt || fault;
		// Wait only counts with a nonzero distance.
		wait_elapsed = (ms_count >= jog_wait_time);
	end

	jog_speed_clamp #(.WIDTH(16)) speed_clamp (
		.slow_speed    (jog_slow_speed),
		.fast_speed    (jog_fast_speed),
		.select_fast   (use_fast),
		.max_ramp_speed(max_ramp_speed),
		.speed         (clamped_speed)
	);

	always_comb begin
		next_state        = state;
		next_inch_request = 1'b0;
		next_done         = 1'b0;
		// Step from the present axis position.
		next_target = dir_ccw ? (axis_position - jog_inch_distance)
			: (axis_position + jog_inch_distance);
		unique case (state)
			st_idle: begin
				if (mode_request && !abort) begin
					next_state = st_armed;
				end
			end
			st_armed: begin
				if (abort) begin
					next_state = st_ending;
				end else if (!mode_request) begin
					next_state = st_idle;
				end else if (dir_valid) begin
					// Zero distance runs continuously at once.
					if (jog_inch_distance == 32'h0000_0000) begin
						next_state = st_continuous;
					end else begin
						next_state        = st_inching;
						next_inch_request = 1'b1;
					end
				end
			end
			st_inching: begin
				if (abort || !mode_request) begin
					next_state = st_ending;
				end else if (!dir_valid) begin
					next_state = st_stopping;
				end else if (wait_elapsed) begin
					next_state = st_continuous;
				end
			end
			st_continuous: begin
				if (abort || !mode_request) begin
					next_state = st_ending;
				end else if (!dir_valid) begin
					next_state = st_stopping;
				end
			end
			st_stopping: begin
				if (abort) begin
					next_state = st_ending;
				end else if (motor_stopped && !dir_valid) begin
					next_state = st_armed;
					next_done  = 1'b1;
				end
			end
			st_ending: begin
				if (motor_stopped) begin
					next_state = st_idle;
					next_done  = 1'b1;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state          <= st_idle;
			jog_active     <= 1'b0;
			power_enable   <= 1'b0;
			inch_request   <= 1'b0;
			jog_done       <= 1'b0;
			run_continuous <= 1'b0;
		end else if (ce) begin
			state          <= next_state;
			jog_active     <= (next_state != st_idle);
			// Motor energized while jog mode is entered.
			power_enable   <= (next_state != st_idle);
			inch_request   <= next_inch_request;
			jog_done       <= next_done;
			run_continuous <= (next_state == st_continuous);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			inch_target <= 32'h0000_0000;
			run_ccw     <= 1'b0;
		end else if (ce) begin
			if (state == st_armed && dir_valid) begin
				inch_target <= next_target;
				run_ccw     <= dir_ccw;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			speed_ref <= 16'h0000;
		end else if (ce) begin
			speed_ref <= (next_state inside {st_inching, st_continuous, st_stopping}) ?
				clamped_speed : 16'h0000;
		end
	end

	// Millisecond timebase for the wait before continuous running.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prescale <= '0;
			ms_count <= 16'h0000;
		end else if (ce) begin
			if (state != st_inching) begin
				prescale <= '0;
				ms_count <= 16'h0000;
			end else if (prescale == PRESCALE_LAST) begin
				prescale <= '0;
				if (ms_count != 16'hffff) begin
					ms_count <= ms_count + 16'h0001;
				end
			end else begin
				prescale <= prescale + PW'(1);
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_opmode_start: assert property (
		ce && state == st_idle && write_ok && param_address == ADDR_OPMODE &&
		param_write_data[15:0] == OPMODE_JOG && !abort
		|=> ##1 (!ce || jog_active || abort))
		else $error("jog write did not start jog");
	chk_inch_step: assert property (
		inch_request |-> state == st_inching && jog_inch_distance != 32'h0000_0000)
		else $error("inching step issued outside inching");
	chk_wait_elapse: assert property (
		ce && state == st_inching && wait_elapsed && dir_valid && !abort && mode_request
		|=> run_continuous)
		else $error("held request did not go continuous");
	chk_zero_inch: assert property (
		ce && state == st_armed && dir_valid && !abort && mode_request &&
		jog_inch_distance == 32'h0000_0000 |=> run_continuous && !inch_request)
		else $error("zero distance did not go continuous");
	chk_request_range: assert property (
		jog_request <= REQ_MAX)
		else $error("jog request out of range");
	chk_speed_range: assert property (
		jog_slow_speed >= SPEED_MIN && jog_slow_speed <= SPEED_MAX &&
		jog_fast_speed >= SPEED_MIN && jog_fast_speed <= SPEED_MAX)
		else $error("jog speed out of range");
	chk_speed_clamp: assert property (
		ce |=> speed_ref <= $past(max_ramp_speed))
		else $error("speed above ramp maximum");
	chk_wait_early: assert property (
		ce && state == st_inching && !wait_elapsed |=> !run_continuous)
		else $error("continuous before wait time");
	chk_release_done: assert property (
		jog_done |-> $past(motor_stopped))
		else $error("done without standstill");
	chk_halt_end: assert property (
		ce && halt && state != st_idle |=> !run_continuous && !inch_request)
		else $error("motion after halt");
	chk_keypad_power: assert property (
		ce && keypad_jog_menu && !abort && state == st_idle |=> power_enable)
		else $error("keypad menu did not energize motor");
	chk_both_dirs: assert property (
		ce && state == st_armed && dir_bits == 2'b11 |=> state != st_inching &&
		!run_continuous)
		else $error("motion with both directions");

	cov_inch_then_run: cover property (state == st_inching ##1 state == st_continuous);
	cov_release_done: cover property (state == st_stopping ##1 jog_done);
	cov_halt_end: cover property (state == st_ending ##1 state == st_idle);
	cov_keypad_toggle: cover property ($changed(keypad_fast));

endmodule : jog_motion_control

/* File: core/jog_pkg.sv */
package jog_pkg;

	// Holding-register addresses of the jog parameter set.
	localparam logic [15:0] ADDR_OPMODE        = 16'h1b06;
	localparam logic [15:0] ADDR_JOG_REQUEST   = 16'h1b12;
	localparam logic [15:0] ADDR_JOG_STATUS    = 16'h1b20;
	localparam logic [15:0] ADDR_SLOW_SPEED    = 16'h2908;
	localparam logic [15:0] ADDR_FAST_SPEED    = 16'h290a;
	localparam logic [15:0] ADDR_INCH_DISTANCE = 16'h290e;
	localparam logic [15:0] ADDR_WAIT_TIME     = 16'h2910;

	// Field positions of the jog request word.
	localparam int REQ_CW_BIT   = 0;
	localparam int REQ_CCW_BIT  = 1;
	localparam int REQ_FAST_BIT = 2;
	localparam logic [15:0] REQ_MAX = 16'h0007;

	// Operating-mode codes, two's complement.
	localparam logic [15:0] OPMODE_JOG = 16'hffff;
	localparam logic [15:0] OPMODE_MIN = 16'hfff9;
	localparam logic [15:0] OPMODE_MAX = 16'h0006;

	// Values after reset.
	localparam logic [15:0] RESET_OPMODE        = 16'h0000;
	localparam logic [15:0] RESET_JOG_REQUEST   = 16'h0000;
	localparam logic [15:0] RESET_SLOW_SPEED    = 16'h003c;
	localparam logic [15:0] RESET_FAST_SPEED    = 16'h00b4;
	localparam logic [31:0] RESET_INCH_DISTANCE = 32'h0000_0014;
	localparam logic [15:0] RESET_WAIT_TIME     = 16'h01f4;

	// Legal ranges.
	localparam logic [15:0] SPEED_MIN = 16'h0001;
	localparam logic [15:0] SPEED_MAX = 16'h3390;
	localparam logic [15:0] WAIT_MIN  = 16'h0001;
	localparam logic [15:0] WAIT_MAX  = 16'h7fff;

	// Timing.
	localparam int CLOCK_PERIOD_NS = 25;
	localparam int MS_NS           = 1000000;
	localparam int MS_CYCLES       = (MS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	typedef enum logic [5:0] {
		st_idle       = 6'b000001,
		st_armed      = 6'b000010,
		st_inching    = 6'b000100,
		st_continuous = 6'b001000,
		st_stopping   = 6'b010000,
		st_ending     = 6'b100000
	} jog_state_type;

endpackage : jog_pkg

/* File: core/jog_speed_clamp.sv */
`timescale 1ns/1ps

module jog_speed_clamp #(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0] slow_speed,
	input  wire logic [WIDTH-1:0] fast_speed,
	input  wire logic             select_fast,
	input  wire logic [WIDTH-1:0] max_ramp_speed,
	output logic      [WIDTH-1:0] speed
);

	logic [WIDTH-1:0] chosen;

	always_comb begin
		chosen = select_fast ? fast_speed : slow_speed;
		speed = (chosen > max_ramp_speed) ? max_ramp_speed : chosen;
	end

endmodule : jog_speed_clamp

/* File: tb/jog_master_model.sv */
`timescale 1ns/1ps

module jog_master_model (
	input  wire logic        clock,
	output logic             param_write,
	output logic             param_read,
	output logic      [15:0] param_address,
	output logic      [31:0] param_write_data,
	input  wire logic [31:0] param_read_data,
	input  wire logic        param_read_valid,
	input  wire logic        param_error
);
	initial begin
		param_write      = 1'b0;
		param_read       = 1'b0;
		param_address    = 16'h0000;
		param_write_data = 32'h0000_0000;
	end

	task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic valid, output logic err);
		@(posedge clock);
		param_write      <= wr;
		param_read       <= ~wr;
		param_address    <= addr;
		param_write_data <= wdata;
		@(posedge clock);
		param_write      <= 1'b0;
		param_read       <= 1'b0;
		param_address    <= ~addr;
		param_write_data <= ~wdata;
		#1;
		rdata = param_read_data;
		valid = param_read_valid;
		err   = param_error;
	endtask : access
endmodule : jog_master_model

/* File: tb/jog_motion_control_bench.sv */
`timescale 1ns/1ps

module jog_motion_control_bench;
	import jog_pkg::*;

	logic        clock, rst_n, ce, param_write, param_read, param_read_valid, param_error;
	logic [15:0] param_address, max_ramp_speed, speed_ref;
	logic [31:0] param_write_data, param_read_data, axis_position, inch_target;
	logic        motor_stopped, halt, fault, keypad_jog_menu, keypad_up_key;
	logic        keypad_down_key, keypad_enter_key, power_enable, jog_active;
	logic        inch_request, run_continuous, run_ccw, jog_done;
	int          err_count, num_checks, n;

	jog_master_model master (.clock(clock), .param_write(param_write),
		.param_read(param_read), .param_address(param_address),
		.param_write_data(param_write_data), .param_read_data(param_read_data),
		.param_read_valid(param_read_valid), .param_error(param_error));

	jog_motion_control #(.MS_CYCLES(4)) DUT (.clock(clock), .rst_n(rst_n), .ce(ce),
		.param_write(param_write), .param_read(param_read), .param_address(param_address),
		.param_write_data(param_write_data), .param_read_data(param_read_data),
		.param_read_valid(param_read_valid), .param_error(param_error),
		.max_ramp_speed(max_ramp_speed), .axis_position(axis_position),
		.motor_stopped(motor_stopped), .halt(halt), .fault(fault),
		.keypad_jog_menu(keypad_jog_menu), .keypad_up_key(keypad_up_key),
		.keypad_down_key(keypad_down_key), .keypad_enter_key(keypad_enter_key),
		.power_enable(power_enable), .jog_active(jog_active), .inch_request(inch_request),
		.inch_target(inch_target), .run_continuous(run_continuous), .run_ccw(run_ccw),
		.speed_ref(speed_ref), .jog_done(jog_done));

	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	task automatic check_flag(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask : check_flag

	task automatic wr(input logic [15:0] addr, input logic [31:0] data, input logic exp_err);
		logic [31:0] d;
		logic        v, e;
		master.access(1'b1, addr, data, d, v, e);
		check_flag("param_error", exp_err, e);
	endtask : wr

	task automatic rd(input logic [15:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		logic        v, e;
		master.access(1'b0, addr, 32'h0000_0000, d, v, e);
		check_flag("param_read_valid", 1'b1, v);
		check_word("param_read_data", exp, d);
	endtask : rd

	// Waits for inch_request (0), run_continuous (1) or jog_done (2).
	task automatic wait_for(input int sel, output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'b0;
		while (hit !== 1'b1) begin
			@(posedge clock);
			#1;
			cnt++;
			hit = (sel == 0) ? inch_request : (sel == 1) ? run_continuous : jog_done;
			if (cnt > 200) begin
				err_count++;
				$display("CHECK FAILED wait %0d expected 1 seen timeout", sel);
				give_verdict();
			end
		end
	endtask : wait_for

	task automatic t_registers();
		rd(ADDR_SLOW_SPEED, 32'h0000_003c);
		rd(ADDR_FAST_SPEED, 32'h0000_00b4);
		rd(ADDR_INCH_DISTANCE, 32'h0000_0014);
		rd(ADDR_WAIT_TIME, 32'h0000_01f4);
		wr(ADDR_FAST_SPEED, 32'h0000_3391, 1'b1);
		wr(ADDR_SLOW_SPEED, 32'h0000_0000, 1'b1);
		wr(ADDR_WAIT_TIME, 32'h0000_8000, 1'b1);
		wr(ADDR_JOG_REQUEST, 32'h0000_0008, 1'b1);
		wr(16'h1234, 32'h0000_0000, 1'b1);
		wr(ADDR_SLOW_SPEED, 32'h0000_3390, 1'b0);
		rd(ADDR_SLOW_SPEED, 32'h0000_3390);
		wr(ADDR_SLOW_SPEED, 32'h0000_003c, 1'b0);
		wr(ADDR_WAIT_TIME, 32'h0000_0002, 1'b0);
	endtask : t_registers

	task automatic t_inching();
		wr(ADDR_OPMODE, 32'h0000_ffff, 1'b0);
		@(posedge clock);
		#1;
		check_flag("jog_active", 1'b1, jog_active);
		rd(ADDR_OPMODE, 32'hffff_ffff);
		@(posedge clock) motor_stopped <= 1'b0;
		wr(ADDR_JOG_REQUEST, 32'h0000_0001, 1'b0);
		wait_for(0, n);
		check_word("inch_target", 32'h0000_1014, inch_target);
		check_word("speed_ref", 32'h0000_003c, {16'h0000, speed_ref});
		check_flag("run_ccw", 1'b0, run_ccw);
		wait_for(1, n);
		check_flag("continuous delay", 1'b1, n >= 8 && n <= 10);
		wr(ADDR_JOG_REQUEST, 32'h0000_0000, 1'b0);
		repeat (3) @(posedge clock);
		#1;
		check_flag("run_continuous", 1'b0, run_continuous);
		check_flag("jog_done", 1'b0, jog_done);
		@(posedge clock) motor_stopped <= 1'b1;
		wait_for(2, n);
		check_flag("jog_active", 1'b1, jog_active);
	endtask : t_inching

	task automatic t_zero_distance();
		@(posedge clock) max_ramp_speed <= 16'h0064;
		wr(ADDR_INCH_DISTANCE, 32'h0000_0000, 1'b0);
		wr(ADDR_JOG_REQUEST, 32'h0000_0003, 1'b0);
		repeat (3) @(posedge clock);
		#1;
		check_flag("inch_request", 1'b0, inch_request | run_continuous);
		@(posedge clock) motor_stopped <= 1'b0;
		wr(ADDR_JOG_REQUEST, 32'h0000_0006, 1'b0);
		wait_for(1, n);
		check_flag("direct continuous", 1'b1, n <= 2);
		check_flag("run_ccw", 1'b1, run_ccw);
		check_word("speed_ref", 32'h0000_0064, {16'h0000, speed_ref});
		wr(ADDR_FAST_SPEED, 32'h0000_005a, 1'b0);
		@(posedge clock);
		#1;
		check_word("speed_ref", 32'h0000_005a, {16'h0000, speed_ref});
	endtask : t_zero_distance

	task automatic t_halt();
		@(posedge clock) halt <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		check_flag("jog_done", 1'b0, jog_done);
		@(posedge clock) motor_stopped <= 1'b1;
		wait_for(2, n);
		@(posedge clock) halt <= 1'b0;
		#1;
		check_flag("jog_active", 1'b0, jog_active);
	endtask : t_halt

	task automatic t_keypad();
		@(posedge clock) keypad_jog_menu <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check_flag("power_enable", 1'b1, power_enable);
		@(posedge clock) motor_stopped <= 1'b0;
		keypad_down_key <= 1'b1;
		wait_for(1, n);
		check_flag("run_ccw", 1'b1, run_ccw);
		check_word("speed_ref", 32'h0000_003c, {16'h0000, speed_ref});
		@(posedge clock) keypad_enter_key <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		check_word("speed_ref", 32'h0000_005a, {16'h0000, speed_ref});
		@(posedge clock) ce <= 1'b0;
		keypad_down_key <= 1'b0;
		keypad_enter_key <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check_flag("run_continuous", 1'b1, run_continuous);
		@(posedge clock) ce <= 1'b1;
		motor_stopped <= 1'b1;
		wait_for(2, n);
	endtask : t_keypad

	initial begin
		err_count = 0;
		num_checks = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		max_ramp_speed = 16'h3390;
		axis_position = 32'h0000_1000;
		motor_stopped = 1'b1;
		{halt, fault, keypad_jog_menu, keypad_up_key} = 4'h0;
		{keypad_down_key, keypad_enter_key} = 2'b00;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		t_registers();
		t_inching();
		t_zero_distance();
		t_halt();
		t_keypad();
		give_verdict();
	end
endmodule : jog_motion_control_bench
